// [sim/rtc_countdown_and_calendar_asserts.sv]
// Port-level checks of the RTC block
`timescale 1ns/10ps
module rtc_countdown_and_calendar_asserts (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic low_power,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic alarm_irq,
  input wire logic countdown_irq,
  input wire logic combined_rtc_irq
);
  logic wr_r;
  logic [7:0] adr_r;
  logic [1:0] msk_r;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Mirror of the mask register, taken from bus writes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_r <= 1'b0;
      adr_r <= 8'h00;
      msk_r <= 2'h0;
    end else begin
      wr_r <= hsel && hready && htrans[1] && hwrite;
      adr_r <= haddr[7:0];
      if (wr_r && adr_r == rtc_pkg::A_MASK) begin
        msk_r <= hwdata[1:0];
      end
    end
  end
  sequence s_rd(logic [7:0] a);
    hsel && hready && htrans[1] && !hwrite && haddr[7:0] == a;
  endsequence
  property p_comb;
    combined_rtc_irq == (alarm_irq || countdown_irq);
  endproperty
  property p_ready;
    $past(hresetn) |-> hreadyout && !hresp;
  endproperty
  property p_unmap;
    s_rd(8'h18) |=> hrdata == 32'h0000_0000;
  endproperty
  property p_mask_rd;
    s_rd(rtc_pkg::A_MASK) |=> hrdata[1:0] == msk_r;
  endproperty
  property p_mskd;
    s_rd(rtc_pkg::A_MSKD) |=> (hrdata[1:0] & ~msk_r) == 2'h0;
  endproperty
  property p_off;
    !msk_r[0] [*3] |-> !alarm_irq;
  endproperty
  property p_secmin;
    s_rd(rtc_pkg::A_TIME) |=> hrdata[5:0] <= rtc_pkg::SEC_MAX && hrdata[11:6] <= rtc_pkg::SEC_MAX;
  endproperty
  property p_hour;
    s_rd(rtc_pkg::A_TIME) |=> hrdata[16:12] <= rtc_pkg::HOUR_MAX;
  endproperty
  property p_wday;
    s_rd(rtc_pkg::A_TIME) |=> hrdata[19:17] != 3'h0 && hrdata[24:20] != 5'h00;
  endproperty
  property p_mon;
    s_rd(rtc_pkg::A_TIME) |=> hrdata[28:25] inside {[4'h1:rtc_pkg::MON_MAX]};
  endproperty
  property p_year;
    s_rd(rtc_pkg::A_YEAR) |=> hrdata[12:0] <= rtc_pkg::YEAR_MAX;
  endproperty
  a_comb: assert property (p_comb) else $error("combined irq mismatch");
  a_ready: assert property (p_ready) else $error("bus not ready or not okay");
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  a_mask_rd: assert property (p_mask_rd) else $error("mask readback");
  a_mskd: assert property (p_mskd) else $error("masked status not masked");
  a_off: assert property (p_off) else $error("masked alarm drives irq");
  a_secmin: assert property (p_secmin) else $error("seconds or minutes range");
  a_hour: assert property (p_hour) else $error("hours range");
  a_wday: assert property (p_wday) else $error("weekday or day zero");
  a_mon: assert property (p_mon) else $error("month range");
  a_year: assert property (p_year) else $error("year range");
endmodule

// [sim/rtc_countdown_and_calendar_tb.sv]
// Self-checking bench: bus access, calendar, alarm and interval timer
`timescale 1ns/10ps
`define chk(g, e) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module rtc_countdown_and_calendar_tb;
  localparam int LSD = 4;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b1, hwrite = 1'b0, low_power = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q, p;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic hready, hreadyout, hresp, alarm_irq, countdown_irq, combined_rtc_irq;
  int n_errors = 0, num_checks = 0, cyc = 0, t0, k;
  logic [31:0] pre_y [3] = '{32'h7E7, 32'h7E8, 32'h7E8};
  logic [31:0] exp_y [3] = '{32'h7E7, 32'h7E8, 32'h7E9};
  logic [31:0] pre_t [3], exp_t [3];
  always #25 hclk = ~hclk;
  // Counted on the falling edge so reads after a rising edge never race it
  always @(negedge hclk) cyc++;
  assign hready = hreadyout;
  rtc_countdown_and_calendar #(.LS_DIV(LSD), .SEC_DIV(8)) uut (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .low_power(low_power),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .alarm_irq(alarm_irq),
    .countdown_irq(countdown_irq), .combined_rtc_irq(combined_rtc_irq));
  function automatic logic [31:0] tm(input logic [3:0] mo, input logic [4:0] md,
    input logic [2:0] wd, input logic [4:0] h, input logic [5:0] mi, input logic [5:0] s);
    return {3'h0, mo, md, wd, h, mi, s};
  endfunction
  task automatic final_report;
    $display("errors %0d checks %0d", n_errors, num_checks);
    if (n_errors == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic wt;
    int i;
    i = 0;
    @(posedge hclk);
    while (hready !== 1'b1) begin
      i++;
      if (i > 50) begin
        n_errors++;
        final_report;
      end
      @(posedge hclk);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    wt();
    htrans <= 2'h0;
    hwdata <= d;
    wt();
    q = hrdata;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `chk(q, e)
  endtask
  task automatic until_eq(input logic [7:0] a, input logic [31:0] e);
    int i;
    for (i = 0; i < 300; i++) begin
      bus(1'b0, a, 32'h0);
      if (q === e) break;
    end
    `chk(q, e)
    if (i == 300) final_report;
  endtask
  task automatic irq_wait;
    int i;
    // Let a just-written clear reach the output first
    repeat (2) @(posedge hclk);
    for (i = 0; i < 400 && countdown_irq !== 1'b1; i++) begin
      @(posedge hclk);
    end
    `chk(countdown_irq, 1'b1)
    if (i == 400) final_report;
  endtask
  task automatic per(input int n);
    irq_wait;
    bus(1'b1, rtc_pkg::A_CLR, 32'h2);
    irq_wait;
    t0 = cyc;
    bus(1'b1, rtc_pkg::A_CLR, 32'h2);
    irq_wait;
    `chk(cyc - t0, n * LSD)
  endtask
  task automatic ctl(input logic [31:0] d);
    repeat (20) @(posedge hclk);
    bus(1'b1, rtc_pkg::A_TCTL, d);
  endtask
  initial begin
    pre_t = '{tm(2, 28, 7, 23, 59, 59), tm(2, 28, 3, 23, 59, 59), tm(12, 31, 5, 23, 59, 59)};
    exp_t = '{tm(3, 1, 1, 0, 0, 0), tm(2, 29, 4, 0, 0, 0), tm(1, 1, 6, 0, 0, 0)};
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    rc(rtc_pkg::A_TIME, rtc_pkg::TIME_RST);
    rc(rtc_pkg::A_TCNT, rtc_pkg::TCNT_RST);
    rc(rtc_pkg::A_YEAR, {19'h0, rtc_pkg::YEAR_RST[12:0]});
    rc(8'h18, 32'h0);
    rc(rtc_pkg::A_RAW, 32'h0);
    bus(1'b1, rtc_pkg::A_ALM_TIME, 32'h0);
    bus(1'b1, rtc_pkg::A_ALM_YEAR, 32'h0);
    for (k = 0; k < 3; k++) begin
      bus(1'b1, rtc_pkg::A_MASK, {31'h0, k != 1});
      bus(1'b1, rtc_pkg::A_PRE_YEAR, pre_y[k]);
      bus(1'b1, rtc_pkg::A_PRE_TIME, pre_t[k]);
      until_eq(rtc_pkg::A_TIME, exp_t[k]);
      rc(rtc_pkg::A_YEAR, exp_y[k]);
      rc(rtc_pkg::A_RAW, 32'h1);
      rc(rtc_pkg::A_MSKD, {31'h0, k != 1});
      `chk(combined_rtc_irq, k != 1)
      `chk(alarm_irq, k != 1)
      bus(1'b1, rtc_pkg::A_CLR, 32'h1);
      rc(rtc_pkg::A_RAW, 32'h0);
    end
    low_power <= 1'b1;
    bus(1'b0, rtc_pkg::A_TIME, 32'h0);
    p = q;
    repeat (80) @(posedge hclk);
    rc(rtc_pkg::A_TIME, p);
    low_power <= 1'b0;
    bus(1'b1, rtc_pkg::A_MASK, 32'h2);
    bus(1'b1, rtc_pkg::A_RLD1, 32'h5);
    bus(1'b1, rtc_pkg::A_TCTL, 32'h3);
    t0 = cyc;
    irq_wait;
    `chk(cyc - t0 inside {[5 * LSD:8 * LSD]}, 1'b1)
    bus(1'b1, rtc_pkg::A_CLR, 32'h2);
    repeat (60) @(posedge hclk);
    rc(rtc_pkg::A_RAW, 32'h0);
    rc(rtc_pkg::A_TCNT, 32'h0);
    rc(rtc_pkg::A_TCTL, 32'h1);
    rc(rtc_pkg::A_INUM, 32'h1);
    bus(1'b1, rtc_pkg::A_RLD2, 32'h9);
    bus(1'b1, rtc_pkg::A_PAT0, 32'hFFFF_FFFF);
    bus(1'b1, rtc_pkg::A_RLD1, 32'h2);
    bus(1'b1, rtc_pkg::A_TCTL, 32'h32);
    // Deliberate write while running, expected to be dropped
    bus(1'b1, rtc_pkg::A_RLD1, 32'h7);
    rc(rtc_pkg::A_RLD1, 32'h2);
    rc(rtc_pkg::A_RLD2, 32'h9);
    per(10);
    ctl(32'h0);
    bus(1'b1, rtc_pkg::A_PAT0, 32'h0);
    ctl(32'h32);
    per(3);
    ctl(32'h0);
    bus(1'b1, rtc_pkg::A_CLR, 32'h2);
    ctl(32'h5);
    bus(1'b1, rtc_pkg::A_RLD1, 32'h8);
    repeat (LSD + 1) @(posedge hclk);
    rc(rtc_pkg::A_TCTL, 32'h7);
    irq_wait;
    final_report;
  end
endmodule
bind rtc_countdown_and_calendar rtc_countdown_and_calendar_asserts chk_i (.hclk(hclk),
  .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hsize(hsize), .hwdata(hwdata), .hready(hready), .low_power(low_power),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .alarm_irq(alarm_irq),
  .countdown_irq(countdown_irq), .combined_rtc_irq(combined_rtc_irq));

// [verilog/rtc_countdown_and_calendar.sv]
// RTC: interval timer with reload pattern and calendar clock with alarm, AHB-Lite slave
`timescale 1ns/10ps
module rtc_countdown_and_calendar #(
  parameter int unsigned LS_DIV = rtc_pkg::LS_DIV,
  parameter int unsigned SEC_DIV = rtc_pkg::SEC_DIV
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic low_power,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic alarm_irq,
  output logic countdown_irq,
  output logic combined_rtc_irq
);
  // Address phase capture
  logic wr_pend_r;
  logic rd_pend_r;
  logic [7:0] addr_r;
  wire addr_ok = hsel && hready && htrans[1];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      addr_r <= 8'h00;
    end else begin
      wr_pend_r <= addr_ok && hwrite;
      rd_pend_r <= addr_ok && !hwrite;
      if (addr_ok) begin
        addr_r <= haddr[7:0];
      end
    end
  end
  // Zero-wait slave, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  wire we_alm_time = wr_pend_r && addr_r == rtc_pkg::A_ALM_TIME;
  wire we_pre_time = wr_pend_r && addr_r == rtc_pkg::A_PRE_TIME;
  wire we_alm_year = wr_pend_r && addr_r == rtc_pkg::A_ALM_YEAR;
  wire we_pre_year = wr_pend_r && addr_r == rtc_pkg::A_PRE_YEAR;
  wire we_mask = wr_pend_r && addr_r == rtc_pkg::A_MASK;
  wire we_clr = wr_pend_r && addr_r == rtc_pkg::A_CLR;
  wire we_tctl = wr_pend_r && addr_r == rtc_pkg::A_TCTL;
  wire we_rld1 = wr_pend_r && addr_r == rtc_pkg::A_RLD1;
  wire we_rld2 = wr_pend_r && addr_r == rtc_pkg::A_RLD2;
  wire we_pat = wr_pend_r && addr_r >= rtc_pkg::A_PAT0 && addr_r <= rtc_pkg::A_PAT3;
  wire [1:0] pat_word = 2'((addr_r - rtc_pkg::A_PAT0) >> 2);

  // Clock gating in low-power: nothing advances
  logic [15:0] ls_cnt_r;
  logic [15:0] sec_cnt_r;
  logic ls_tick_r;
  logic one_hertz_tick;
  wire ls_wrap = ls_cnt_r == 16'(LS_DIV - 1);
  wire sec_wrap = sec_cnt_r == 16'(SEC_DIV - 1);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ls_cnt_r <= 16'h0000;
      sec_cnt_r <= 16'h0000;
      ls_tick_r <= 1'b0;
      one_hertz_tick <= 1'b0;
    end else begin
      ls_tick_r <= 1'b0;
      one_hertz_tick <= 1'b0;
      if (!low_power) begin
        ls_cnt_r <= ls_wrap ? 16'h0000 : ls_cnt_r + 16'h0001;
        if (ls_wrap) begin
          ls_tick_r <= 1'b1;
          sec_cnt_r <= sec_wrap ? 16'h0000 : sec_cnt_r + 16'h0001;
          one_hertz_tick <= sec_wrap;
        end
      end
    end
  end

  // Timer control and reload registers
  logic [31:0] countdown_control_reg;
  logic [31:0] first_reload_value;
  logic [31:0] second_reload_value;
  logic [127:0] pattern_r;
  logic [31:0] tcnt_r;
  logic [6:0] pidx_r;
  logic [31:0] inum_r;
  logic load_pend_r;
  wire timer_oneshot_select = countdown_control_reg[rtc_pkg::TC_ONESHOT];
  wire timer_run_enable = countdown_control_reg[rtc_pkg::TC_RUN];
  wire self_start = countdown_control_reg[rtc_pkg::TC_SELF];
  wire [6:0] plen = countdown_control_reg[rtc_pkg::TC_PLEN_HI:rtc_pkg::TC_PLEN_LO];
  wire rld_ok = !timer_run_enable;
  wire rld_wr = (we_rld1 || we_rld2) && rld_ok;
  wire t_zero = tcnt_r == 32'h0000_0000;
  wire t_step = timer_run_enable && ls_tick_r;
  wire t_event = t_step && t_zero;
  wire [6:0] pidx_next = (pidx_r >= plen) ? 7'h00 : pidx_r + 7'h01;
  wire pbit = pattern_r[pidx_next];
  wire [31:0] reload_sel = pbit ? second_reload_value : first_reload_value;
  wire run_set = rld_wr && self_start;
  wire run_clr = t_event && timer_oneshot_select;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      countdown_control_reg <= 32'h0000_0000;
    end else if (we_tctl) begin
      countdown_control_reg <= {21'h000000, hwdata[10:4], 1'b0, hwdata[2:0]};
    end else if (run_set || (we_rld1 && rld_ok && timer_oneshot_select)) begin
      countdown_control_reg[rtc_pkg::TC_RUN] <= 1'b1;
    end else if (run_clr) begin
      countdown_control_reg[rtc_pkg::TC_RUN] <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      first_reload_value <= 32'h0000_0000;
      second_reload_value <= 32'h0000_0000;
    end else begin
      if (we_rld1 && rld_ok) begin
        first_reload_value <= hwdata;
      end
      if (we_rld2 && rld_ok) begin
        second_reload_value <= hwdata;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pattern_r <= 128'h0;
    end else if (we_pat) begin
      pattern_r[pat_word*32 +: 32] <= hwdata;
    end
  end

  // New count starts from the first reload value after a reload write while halted, or a restart
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tcnt_r <= rtc_pkg::TCNT_RST;
      pidx_r <= 7'h00;
      inum_r <= 32'h0000_0000;
      load_pend_r <= 1'b0;
    end else begin
      if (rld_wr || (we_tctl && hwdata[rtc_pkg::TC_RUN] && !timer_run_enable)) begin
        load_pend_r <= 1'b1;
        pidx_r <= 7'h00;
      end else if (load_pend_r) begin
        load_pend_r <= 1'b0;
        tcnt_r <= first_reload_value;
      end else if (t_event) begin
        inum_r <= inum_r + 32'h0000_0001;
        if (!timer_oneshot_select) begin
          tcnt_r <= reload_sel;
          pidx_r <= pidx_next;
        end
      end else if (t_step) begin
        tcnt_r <= tcnt_r - 32'h0000_0001;
      end
    end
  end

  // Calendar
  rtc_pkg::cal_time_t now_r;
  rtc_pkg::cal_time_t calendar_time_preset;
  rtc_pkg::cal_time_t alarm_time_compare;
  logic [12:0] calendar_year_count;
  logic [12:0] calendar_year_preset;
  logic [12:0] alarm_year_compare;
  logic preset_pend_r;
  logic cmp_pend_r;
  wire [31:0] calendar_time_count = now_r;

  wire leap = calendar_year_count[1:0] == 2'b00;
  logic [4:0] mday_max;
  always_comb begin
    case (now_r.month)
      4'h4, 4'h6, 4'h9, 4'hB: mday_max = 5'h1E;
      rtc_pkg::MON_FEB: mday_max = leap ? 5'h1D : 5'h1C;
      default: mday_max = 5'h1F;
    endcase
  end
  wire sec_c = now_r.sec == rtc_pkg::SEC_MAX;
  wire min_c = sec_c && now_r.min == rtc_pkg::SEC_MAX;
  wire hour_c = min_c && now_r.hour == rtc_pkg::HOUR_MAX;
  wire mday_c = hour_c && now_r.mday == mday_max;
  wire mon_c = mday_c && now_r.month == rtc_pkg::MON_MAX;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      calendar_time_preset <= '0;
      calendar_year_preset <= 13'h0000;
      alarm_time_compare <= '0;
      alarm_year_compare <= rtc_pkg::YEAR_RST[12:0];
    end else begin
      if (we_pre_time) calendar_time_preset <= {3'b000, hwdata[28:0]};
      if (we_pre_year) calendar_year_preset <= hwdata[12:0];
      if (we_alm_time) alarm_time_compare <= {3'b000, hwdata[28:0]};
      if (we_alm_year) alarm_year_compare <= hwdata[12:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      now_r <= rtc_pkg::TIME_RST;
      calendar_year_count <= rtc_pkg::YEAR_RST[12:0];
      preset_pend_r <= 1'b0;
      cmp_pend_r <= 1'b0;
    end else begin
      cmp_pend_r <= one_hertz_tick;
      if (we_pre_time) begin
        preset_pend_r <= 1'b1;
      end else if (one_hertz_tick && preset_pend_r) begin
        preset_pend_r <= 1'b0;
      end
      if (one_hertz_tick && preset_pend_r && !we_pre_time) begin
        now_r <= calendar_time_preset;
        calendar_year_count <= calendar_year_preset;
      end else if (one_hertz_tick) begin
        now_r.sec <= sec_c ? 6'h00 : now_r.sec + 6'h01;
        if (sec_c) now_r.min <= min_c ? 6'h00 : now_r.min + 6'h01;
        if (min_c) now_r.hour <= hour_c ? 5'h00 : now_r.hour + 5'h01;
        if (hour_c) begin
          now_r.wday <= (now_r.wday == rtc_pkg::WDAY_MAX) ? rtc_pkg::WDAY_MIN
                        : now_r.wday + 3'h1;
          now_r.mday <= mday_c ? 5'h01 : now_r.mday + 5'h01;
        end
        if (mday_c) now_r.month <= mon_c ? 4'h1 : now_r.month + 4'h1;
        if (mon_c) begin
          calendar_year_count <= (calendar_year_count == rtc_pkg::YEAR_MAX) ? 13'h0000
                                 : calendar_year_count + 13'h0001;
        end
      end
    end
  end

  // Alarm compare one cycle after each increment
  wire m_year = alarm_year_compare == 13'h0000 || alarm_year_compare == calendar_year_count;
  wire m_mon = alarm_time_compare.month == 4'h0 || alarm_time_compare.month == now_r.month;
  wire m_mday = alarm_time_compare.mday == 5'h00 || alarm_time_compare.mday == now_r.mday;
  wire m_wday = alarm_time_compare.wday == 3'h0 || alarm_time_compare.wday == now_r.wday;
  wire m_hms = alarm_time_compare.sec == now_r.sec && alarm_time_compare.min == now_r.min
               && alarm_time_compare.hour == now_r.hour;
  wire alarm_event = cmp_pend_r && m_year && m_mon && m_mday && m_wday && m_hms;

  // Interrupt status: set wins over clear
  logic [1:0] raw_r;
  logic [1:0] irq_mask_bits;
  wire [1:0] irq_clear_bits = we_clr ? hwdata[1:0] : 2'b00;
  wire [1:0] irq_set = {t_event, alarm_event};
  wire [1:0] raw_nxt = irq_set | (raw_r & ~irq_clear_bits);
  wire [1:0] msk_nxt = raw_nxt & (we_mask ? hwdata[1:0] : irq_mask_bits);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      raw_r <= 2'b00;
      irq_mask_bits <= 2'b00;
      alarm_irq <= 1'b0;
      countdown_irq <= 1'b0;
      combined_rtc_irq <= 1'b0;
    end else begin
      raw_r <= raw_nxt;
      if (we_mask) irq_mask_bits <= hwdata[1:0];
      alarm_irq <= msk_nxt[rtc_pkg::IRQ_ALARM];
      countdown_irq <= msk_nxt[rtc_pkg::IRQ_TIMER];
      combined_rtc_irq <= |msk_nxt;
    end
  end

  // Read mux
  logic [31:0] rd_mux;
  always_comb begin
    case (haddr[7:0])
      rtc_pkg::A_TIME: rd_mux = calendar_time_count;
      rtc_pkg::A_ALM_TIME: rd_mux = alarm_time_compare;
      rtc_pkg::A_PRE_TIME: rd_mux = calendar_time_preset;
      rtc_pkg::A_YEAR: rd_mux = {19'h0, calendar_year_count};
      rtc_pkg::A_ALM_YEAR: rd_mux = {19'h0, alarm_year_compare};
      rtc_pkg::A_PRE_YEAR: rd_mux = {19'h0, calendar_year_preset};
      rtc_pkg::A_MASK: rd_mux = {30'h0, irq_mask_bits};
      rtc_pkg::A_RAW: rd_mux = {30'h0, raw_r};
      rtc_pkg::A_MSKD: rd_mux = {30'h0, raw_r & irq_mask_bits};
      rtc_pkg::A_TCNT: rd_mux = tcnt_r;
      rtc_pkg::A_TCTL: rd_mux = countdown_control_reg;
      rtc_pkg::A_RLD1: rd_mux = first_reload_value;
      rtc_pkg::A_RLD2: rd_mux = second_reload_value;
      rtc_pkg::A_INUM: rd_mux = inum_r;
      default: rd_mux = 32'h0000_0000;
    endcase
    if (haddr[7:0] >= rtc_pkg::A_PAT0 && haddr[7:0] <= rtc_pkg::A_PAT3) begin
      rd_mux = pattern_r[2'((haddr[7:0] - rtc_pkg::A_PAT0) >> 2)*32 +: 32];
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_ok && !hwrite) begin
      hrdata <= rd_mux;
    end
  end
endmodule

// [verilog/rtc_pkg.sv]
// Package: register map, field layout and timing constants of the RTC block
package rtc_pkg;
  localparam int unsigned HCLK_HZ = 20000000;
  localparam int unsigned LS_HZ = 32768;
  localparam int unsigned LS_DIV = HCLK_HZ / LS_HZ;
  localparam int unsigned SEC_DIV = LS_HZ;

  localparam logic [7:0] A_TIME = 8'h00;
  localparam logic [7:0] A_ALM_TIME = 8'h04;
  localparam logic [7:0] A_PRE_TIME = 8'h08;
  localparam logic [7:0] A_YEAR = 8'h0C;
  localparam logic [7:0] A_ALM_YEAR = 8'h10;
  localparam logic [7:0] A_PRE_YEAR = 8'h14;
  localparam logic [7:0] A_MASK = 8'h1C;
  localparam logic [7:0] A_RAW = 8'h20;
  localparam logic [7:0] A_MSKD = 8'h24;
  localparam logic [7:0] A_CLR = 8'h28;
  localparam logic [7:0] A_TCNT = 8'h2C;
  localparam logic [7:0] A_TCTL = 8'h30;
  localparam logic [7:0] A_RLD1 = 8'h34;
  localparam logic [7:0] A_RLD2 = 8'h38;
  localparam logic [7:0] A_PAT0 = 8'h3C;
  localparam logic [7:0] A_PAT3 = 8'h48;
  localparam logic [7:0] A_INUM = 8'h4C;

  // Timer control bits
  localparam int TC_ONESHOT = 0;
  localparam int TC_RUN = 1;
  localparam int TC_SELF = 2;
  localparam int TC_PLEN_LO = 4;
  localparam int TC_PLEN_HI = 10;
  // Interrupt bits
  localparam int IRQ_ALARM = 0;
  localparam int IRQ_TIMER = 1;

  localparam logic [31:0] TIME_RST = 32'h0212_0000;
  localparam logic [31:0] YEAR_RST = 32'h0000_2000;
  localparam logic [31:0] TCNT_RST = 32'hFFFF_FFFF;
  localparam logic [5:0] SEC_MAX = 6'h3B;
  localparam logic [4:0] HOUR_MAX = 5'h17;
  localparam logic [2:0] WDAY_MAX = 3'h7;
  localparam logic [2:0] WDAY_MIN = 3'h1;
  localparam logic [3:0] MON_MAX = 4'hC;
  localparam logic [3:0] MON_FEB = 4'h2;
  localparam logic [12:0] YEAR_MAX = 13'h1000;

  typedef struct packed {
    logic [2:0] pad;
    logic [3:0] month;
    logic [4:0] mday;
    logic [2:0] wday;
    logic [4:0] hour;
    logic [5:0] min;
    logic [5:0] sec;
  } cal_time_t;
endpackage
